// ==== core/scp_channel.v ====
// One channel of the system control port: output latch, direction
// latch, control register, two interrupt flags and peripheral line.
// Assumes c1_i, c2_i and pin_i are already synchronised to clk_i.
`timescale 1ns/1ns
`include "scp_consts.vh"

module scp_channel #(
   parameter IS_B  = 0,
   parameter WIDTH = 8
) (
   input  wire             clk_i,
   input  wire             rst_i,
   input  wire             acc_i,
   input  wire             we_i,
   input  wire             ctrl_sel_i,
   input  wire [WIDTH-1:0] wdata_i,
   output reg  [WIDTH-1:0] rdata_o,
   input  wire [WIDTH-1:0] pin_i,
   input  wire             c1_i,
   input  wire             c2_i,
   output wire [WIDTH-1:0] port_o,
   output wire [WIDTH-1:0] ddr_o,
   output wire             c2_o,
   output wire             c2_oe_o,
   output wire             irq_n_o
);

   reg  [WIDTH-1:0]        out_r;
   reg  [WIDTH-1:0]        ddr_r;
   reg  [`SCP_CR_W-1:0]    cr_r;
   reg                     f1_r;
   reg                     f2_r;
   reg                     c1_d_r;
   reg                     c2_d_r;
   reg                     c2o_r;
   wire                    c1_edge;
   wire                    c2_edge;
   wire                    data_acc;
   wire                    data_rd;
   wire                    data_wr;
   wire                    c2_strobe;
   wire [WIDTH-1:0]        data_view;

   // Active edge of each control input as chosen by the control register
   assign c1_edge = cr_r[`SCP_CR_C1_RISE] ? (c1_i & ~c1_d_r) : (~c1_i & c1_d_r);
   assign c2_edge = cr_r[`SCP_CR_C2_B4] ? (c2_i & ~c2_d_r) : (~c2_i & c2_d_r);

   // Data location is reached only when the select bit is set
   assign data_acc  = acc_i & ~ctrl_sel_i & cr_r[`SCP_CR_DATA_SEL];
   assign data_rd   = data_acc & ~we_i;
   assign data_wr   = data_acc & we_i;
   assign c2_strobe = (IS_B != 0) ? data_wr : data_rd;

   // Channel B reads its own latch on output lines, channel A the pins
   assign data_view = (IS_B != 0) ? ((out_r & ddr_r) | (pin_i & ~ddr_r)) : pin_i;

   // Register writes, flag tracking and peripheral line state
   always @(posedge clk_i) begin
      if (rst_i) begin
         out_r  <= `SCP_RST_BYTE;
         ddr_r  <= `SCP_RST_BYTE;
         cr_r   <= `SCP_RST_CR;
         f1_r   <= 1'b0;
         f2_r   <= 1'b0;
         c1_d_r <= 1'b0;
         c2_d_r <= 1'b0;
         c2o_r  <= 1'b1;
      end else begin
         c1_d_r <= c1_i;
         c2_d_r <= c2_i;
         if (acc_i & we_i & ~ctrl_sel_i & ~cr_r[`SCP_CR_DATA_SEL]) begin
            ddr_r <= wdata_i;
         end
         if (data_wr) begin
            out_r <= wdata_i;
         end
         if (acc_i & we_i & ctrl_sel_i) begin
            cr_r <= wdata_i[`SCP_CR_W-1:0];
         end
         // A new edge wins over the clearing read
         f1_r <= c1_edge | (f1_r & ~data_rd);
         f2_r <= ~cr_r[`SCP_CR_C2_OUT] & (c2_edge | (f2_r & ~data_rd));
         case (cr_r[`SCP_CR_C2_OUT:`SCP_CR_C2_B3])
            `SCP_C2_HANDSHAKE: begin
               if (c2_strobe) begin
                  c2o_r <= 1'b0;
               end else if (c1_edge) begin
                  c2o_r <= 1'b1;
               end
            end
            `SCP_C2_PULSE: begin
               c2o_r <= ~c2_strobe;
            end
            `SCP_C2_MAN_LOW: begin
               c2o_r <= 1'b0;
            end
            `SCP_C2_MAN_HIGH: begin
               c2o_r <= 1'b1;
            end
            default: begin
               c2o_r <= 1'b1;
            end
         endcase
      end
   end

   // Read view of the addressed location
   always @* begin
      if (ctrl_sel_i) begin
         rdata_o = {f1_r, f2_r, cr_r};
      end else if (cr_r[`SCP_CR_DATA_SEL]) begin
         rdata_o = data_view;
      end else begin
         rdata_o = ddr_r;
      end
   end

   assign port_o  = out_r;
   assign ddr_o   = ddr_r;
   assign c2_o    = c2o_r;
   assign c2_oe_o = cr_r[`SCP_CR_C2_OUT];
   // Interrupt request, low while an enabled flag is set
   assign irq_n_o = ~((f1_r & cr_r[`SCP_CR_C1_EN]) |
                      (f2_r & cr_r[`SCP_CR_C2_B3] & ~cr_r[`SCP_CR_C2_OUT]));

endmodule // scp_channel

// ==== core/scp_consts.vh ====
// Constants for the system control port: port decode, register
// indices, control register fields, pin mapping and reset values.
// Assumes inclusion by bare name from every design file of the block.
`ifndef SCP_CONSTS_VH
`define SCP_CONSTS_VH

// Wishbone byte address: I/O port number sits in bits 9..2
`define SCP_ADR_W          10
`define SCP_ADR_PORT_LO    2
`define SCP_ADR_RS0        2
`define SCP_ADR_RS1        3
`define SCP_ADR_DEC_HI     6
`define SCP_ADR_DEC_LO     4
`define SCP_ADR_LINE7      9
`define SCP_DEC_ABC_LOW    3'h0

// Register indices (port numbers 00h..03h), byte address is index * 4
`define SCP_IDX_DATA_A     2'h0
`define SCP_IDX_CTRL_A     2'h1
`define SCP_IDX_DATA_B     2'h2
`define SCP_IDX_CTRL_B     2'h3

// Control register fields
`define SCP_CR_C1_EN       0
`define SCP_CR_C1_RISE     1
`define SCP_CR_DATA_SEL    2
`define SCP_CR_C2_B3       3
`define SCP_CR_C2_B4       4
`define SCP_CR_C2_OUT      5
`define SCP_CR_W           6

// Peripheral line output modes, control bits 5..3
`define SCP_C2_HANDSHAKE   3'h4
`define SCP_C2_PULSE       3'h5
`define SCP_C2_MAN_LOW     3'h6
`define SCP_C2_MAN_HIGH    3'h7

// Reset values
`define SCP_RST_BYTE       8'h00
`define SCP_RST_CR         6'h00
`define SCP_RST_WORD       32'h00000000

// Channel A line roles
`define SCP_PA_BANK_FIRST  0
`define SCP_PA_BANK_VIDEO  6
`define SCP_PA_BANK_ROM    7

// Channel B line roles
`define SCP_PB_DRIVE_ONE   0
`define SCP_PB_DRIVE_TWO   1
`define SCP_PB_DENSITY     2
`define SCP_PB_BEEPER      3
`define SCP_PB_TX_CLK      4
`define SCP_PB_RX_CLK      5
`define SCP_PB_RING        7

// Synchroniser vector layout
`define SCP_SYNC_W         20
`define SCP_SYNC_PA        0
`define SCP_SYNC_PB        8
`define SCP_SYNC_A_IRQ     16
`define SCP_SYNC_A_LINE    17
`define SCP_SYNC_B_IRQ     18
`define SCP_SYNC_B_LINE    19

`endif

// ==== core/scp_port.v ====
// System control port: Wishbone slave for I/O ports 00h..03h, two
// parallel channels carrying bank enables, drive, modem and beeper lines.
// Assumes a classic Wishbone master on clk_i and pins from other domains.
`timescale 1ns/1ns
`include "scp_consts.vh"

module scp_port #(
   parameter WIDTH = 8
) (
   input  wire                   clk_i,
   input  wire                   rst_i,
   input  wire                   cyc_i,
   input  wire                   stb_i,
   input  wire                   we_i,
   input  wire [`SCP_ADR_W-1:0]  adr_i,
   input  wire [3:0]             sel_i,
   input  wire [31:0]            dat_i,
   output wire [31:0]            dat_o,
   output wire                   ack_o,
   input  wire [WIDTH-1:0]       chan_a_port_i,
   output wire [WIDTH-1:0]       chan_a_port_o,
   output wire [WIDTH-1:0]       chan_a_port_oe_o,
   input  wire [WIDTH-1:0]       chan_b_port_i,
   output wire [WIDTH-1:0]       chan_b_port_o,
   output wire [WIDTH-1:0]       chan_b_port_oe_o,
   input  wire                   chan_a_irq_input_i,
   input  wire                   chan_b_irq_input_i,
   input  wire                   chan_a_periph_line_i,
   output wire                   chan_a_periph_line_o,
   output wire                   chan_a_periph_line_oe_o,
   input  wire                   chan_b_periph_line_i,
   output wire                   chan_b_periph_line_o,
   output wire                   chan_b_periph_line_oe_o,
   output wire                   chan_a_int_request_n_o,
   output wire                   chan_b_int_request_n_o,
   input  wire                   int_request_shared_i,
   output wire                   int_request_shared_o,
   output wire                   int_request_shared_oe_o,
   output wire [WIDTH-1:0]       bank_enable_o,
   output wire                   bank_enable_first_o,
   output wire                   bank_enable_video_o,
   output wire                   bank_enable_rom_o,
   output wire                   frame_rate_50_o,
   output wire                   modem_ring_n_o,
   output wire                   transmit_clock_choice_o,
   output wire                   receive_clock_choice_o,
   output wire                   drive_one_select_n_o,
   output wire                   drive_two_select_n_o,
   output wire                   double_density_n_o,
   output wire                   beeper_o
);

   reg  [`SCP_SYNC_W-1:0]  sync1_r;
   reg  [`SCP_SYNC_W-1:0]  sync2_r;
   reg                     ack_r;
   reg                     ack_nxt;
   reg  [31:0]             dat_r;
   reg  [31:0]             dat_nxt;
   wire [`SCP_SYNC_W-1:0]  pins_raw;
   wire                    io_chip_select_n;
   wire                    address_line_seven;
   wire                    system_port_select_n;
   wire                    commit;
   wire [2*WIDTH-1:0]      rd_bus;
   wire [2*WIDTH-1:0]      port_bus;
   wire [2*WIDTH-1:0]      ddr_bus;
   wire [2*WIDTH-1:0]      pin_bus;
   wire [1:0]              c1_bus;
   wire [1:0]              c2_in_bus;
   wire [1:0]              c2_out_bus;
   wire [1:0]              c2_oe_bus;
   wire [1:0]              irq_n_bus;
   wire [WIDTH-1:0]        pb_eff;
   wire                    ch_b_sel;
   wire [WIDTH-1:0]        rd_sel;

   // Two-stage synchroniser on every pin input except the shared request line, which is not used
   assign pins_raw = {chan_b_periph_line_i, chan_b_irq_input_i,
                      chan_a_periph_line_i, chan_a_irq_input_i,
                      chan_b_port_i, chan_a_port_i};

   always @(posedge clk_i) begin
      if (rst_i) begin
         sync1_r <= {`SCP_SYNC_W{1'b0}};
         sync2_r <= {`SCP_SYNC_W{1'b0}};
      end else begin
         sync1_r <= pins_raw;
         sync2_r <= sync1_r;
      end
   end

   // Port decode: strobe as I/O select, line 7 and decoder inputs low
   assign io_chip_select_n     = ~(cyc_i & stb_i);
   assign address_line_seven   = adr_i[`SCP_ADR_LINE7];
   assign system_port_select_n = io_chip_select_n | address_line_seven |
                                 (adr_i[`SCP_ADR_DEC_HI:`SCP_ADR_DEC_LO] != `SCP_DEC_ABC_LOW);

   // Accesses take effect on the edge where the master sees ack
   assign commit = ~system_port_select_n & ack_r;

   // Address line 1 picks the channel, line 0 data or control
   assign ch_b_sel = adr_i[`SCP_ADR_RS1];
   assign rd_sel   = ch_b_sel ? rd_bus[2*WIDTH-1:WIDTH] : rd_bus[WIDTH-1:0];

   assign pin_bus   = sync2_r[`SCP_SYNC_PB+WIDTH-1:`SCP_SYNC_PA];
   assign c1_bus    = {sync2_r[`SCP_SYNC_B_IRQ], sync2_r[`SCP_SYNC_A_IRQ]};
   assign c2_in_bus = {sync2_r[`SCP_SYNC_B_LINE], sync2_r[`SCP_SYNC_A_LINE]};

   // The two channels
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
         scp_channel #(
            .IS_B  (ch),
            .WIDTH (WIDTH)
         ) u_chan (
            .clk_i      (clk_i),
            .rst_i      (rst_i),
            .acc_i      (commit & (ch_b_sel == ch)),
            .we_i       (we_i & sel_i[0]),
            .ctrl_sel_i (adr_i[`SCP_ADR_RS0]),
            .wdata_i    (dat_i[WIDTH-1:0]),
            .rdata_o    (rd_bus[ch*WIDTH +: WIDTH]),
            .pin_i      (pin_bus[ch*WIDTH +: WIDTH]),
            .c1_i       (c1_bus[ch]),
            .c2_i       (c2_in_bus[ch]),
            .port_o     (port_bus[ch*WIDTH +: WIDTH]),
            .ddr_o      (ddr_bus[ch*WIDTH +: WIDTH]),
            .c2_o       (c2_out_bus[ch]),
            .c2_oe_o    (c2_oe_bus[ch]),
            .irq_n_o    (irq_n_bus[ch])
         );
      end
   endgenerate

   // Bus answer: ack one cycle after the request, read data latched with it
   always @* begin
      ack_nxt = cyc_i & stb_i & ~ack_r;
      dat_nxt = dat_r;
      if (ack_nxt) begin
         if (system_port_select_n) begin
            dat_nxt = `SCP_RST_WORD;
         end else begin
            dat_nxt = {24'h000000, rd_sel};
         end
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= `SCP_RST_WORD;
      end else begin
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
      end
   end

   assign ack_o = ack_r;
   assign dat_o = dat_r;

   // Channel A pins: the bank enables, low while undriven (bank zero)
   assign chan_a_port_o    = port_bus[WIDTH-1:0];
   assign chan_a_port_oe_o = ddr_bus[WIDTH-1:0];
   assign bank_enable_o    = port_bus[WIDTH-1:0] & ddr_bus[WIDTH-1:0];
   assign bank_enable_first_o = bank_enable_o[`SCP_PA_BANK_FIRST];
   assign bank_enable_video_o = bank_enable_o[`SCP_PA_BANK_VIDEO];
   assign bank_enable_rom_o   = bank_enable_o[`SCP_PA_BANK_ROM];

   // Channel B pins; undriven drive and density select lines rest high, ring follows its pin
   assign chan_b_port_o    = port_bus[2*WIDTH-1:WIDTH];
   assign chan_b_port_oe_o = ddr_bus[2*WIDTH-1:WIDTH];
   assign pb_eff = (port_bus[2*WIDTH-1:WIDTH] & ddr_bus[2*WIDTH-1:WIDTH]) |
                   (pin_bus[2*WIDTH-1:WIDTH] & ~ddr_bus[2*WIDTH-1:WIDTH]);
   assign transmit_clock_choice_o = pb_eff[`SCP_PB_TX_CLK] & ddr_bus[WIDTH+`SCP_PB_TX_CLK];
   assign receive_clock_choice_o  = pb_eff[`SCP_PB_RX_CLK] & ddr_bus[WIDTH+`SCP_PB_RX_CLK];
   assign drive_one_select_n_o    = pb_eff[`SCP_PB_DRIVE_ONE] | ~ddr_bus[WIDTH+`SCP_PB_DRIVE_ONE];
   assign drive_two_select_n_o    = pb_eff[`SCP_PB_DRIVE_TWO] | ~ddr_bus[WIDTH+`SCP_PB_DRIVE_TWO];
   assign double_density_n_o      = pb_eff[`SCP_PB_DENSITY] | ~ddr_bus[WIDTH+`SCP_PB_DENSITY];
   assign beeper_o                = pb_eff[`SCP_PB_BEEPER] & ddr_bus[WIDTH+`SCP_PB_BEEPER];
   assign modem_ring_n_o          = pin_bus[WIDTH+`SCP_PB_RING];

   // Peripheral lines
   assign chan_a_periph_line_o    = c2_out_bus[0];
   assign chan_a_periph_line_oe_o = c2_oe_bus[0];
   assign chan_b_periph_line_o    = c2_out_bus[1];
   assign chan_b_periph_line_oe_o = c2_oe_bus[1];
   assign frame_rate_50_o         = c2_out_bus[1] & c2_oe_bus[1];

   // Interrupt requests, open drain onto the shared line
   assign chan_a_int_request_n_o  = irq_n_bus[0];
   assign chan_b_int_request_n_o  = irq_n_bus[1];
   assign int_request_shared_o    = 1'b0;
   assign int_request_shared_oe_o = ~(irq_n_bus[0] & irq_n_bus[1]);

endmodule // scp_port

// ==== verif/scp_cpu_model.sv ====
// Processor side of the port: issues classic Wishbone single cycles.
// Assumes a slave on clk_i that answers each request with ack_i.
`timescale 1ns/1ns
module scp_cpu_model (
   input  wire         clk_i,
   input  wire         ack_i,
   input  wire  [31:0] dat_i,
   output logic        cyc_o,
   output logic        stb_o,
   output logic        we_o,
   output logic [9:0]  adr_o,
   output logic [3:0]  sel_o,
   output logic [31:0] dat_o
);
   bit tmo = 1'b0;

   initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;

   // One request held until ack is sampled, then released
   task automatic xfer(input bit w, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
      int n;
      begin
         @(posedge clk_i);
         {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'h1, 24'h0, d};
         n = 0;
         do begin
            @(posedge clk_i);
            n++;
         end while (ack_i !== 1'b1 && n < 50);
         q = dat_i[7:0];
         tmo = (ack_i !== 1'b1);
         {cyc_o, stb_o, we_o} <= 3'b000;
      end
   endtask
endmodule // scp_cpu_model

// ==== verif/scp_port_checker.sv ====
// Concurrent checks on the system control port pins and bus answer.
// Assumes binding to every scp_port instance with its WIDTH passed on.
`timescale 1ns/1ns
module scp_port_checker #(
   parameter WIDTH = 8
) (
   input wire             clk_i,
   input wire             rst_i,
   input wire             cyc_i,
   input wire             stb_i,
   input wire             ack_o,
   input wire [WIDTH-1:0] chan_a_port_o,
   input wire [WIDTH-1:0] chan_a_port_oe_o,
   input wire [WIDTH-1:0] chan_b_port_i,
   input wire [WIDTH-1:0] chan_b_port_o,
   input wire [WIDTH-1:0] chan_b_port_oe_o,
   input wire             chan_b_periph_line_o,
   input wire             chan_b_periph_line_oe_o,
   input wire             chan_a_int_request_n_o,
   input wire             chan_b_int_request_n_o,
   input wire             int_request_shared_oe_o,
   input wire [WIDTH-1:0] bank_enable_o,
   input wire             bank_enable_first_o,
   input wire             bank_enable_video_o,
   input wire             bank_enable_rom_o,
   input wire             frame_rate_50_o,
   input wire             modem_ring_n_o,
   input wire             transmit_clock_choice_o,
   input wire             receive_clock_choice_o,
   input wire             drive_one_select_n_o,
   input wire             drive_two_select_n_o,
   input wire             double_density_n_o,
   input wire             beeper_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Bus answer, wired request, bank and channel B line mapping
   ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack after request");
   ack_single_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
   irq_wired_a: assert property (int_request_shared_oe_o == (!chan_a_int_request_n_o || !chan_b_int_request_n_o))
      else $error("shared request line wrong");
   bank_drive_a: assert property (bank_enable_o == (chan_a_port_o & chan_a_port_oe_o))
      else $error("bank enables differ from channel A");
   bank_roles_a: assert property ({bank_enable_rom_o, bank_enable_video_o, bank_enable_first_o} ==
      {bank_enable_o[7], bank_enable_o[6], bank_enable_o[0]}) else $error("bank role mapping wrong");
   reset_inputs_a: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=>
      chan_a_port_oe_o == 0 && chan_b_port_oe_o == 0 && bank_enable_o == 0) else $error("reset left drivers");
   frame_sel_a: assert property (frame_rate_50_o == (chan_b_periph_line_o && chan_b_periph_line_oe_o))
      else $error("frame select wrong");
   modem_beep_a: assert property ((!chan_b_port_oe_o[3] || beeper_o == chan_b_port_o[3]) &&
      (!chan_b_port_oe_o[4] || transmit_clock_choice_o == chan_b_port_o[4]) &&
      (!chan_b_port_oe_o[5] || receive_clock_choice_o == chan_b_port_o[5])) else $error("B line wrong");
   disk_sel_a: assert property ((!chan_b_port_oe_o[0] || drive_one_select_n_o == chan_b_port_o[0]) &&
      (!chan_b_port_oe_o[1] || drive_two_select_n_o == chan_b_port_o[1]) &&
      (!chan_b_port_oe_o[2] || double_density_n_o == chan_b_port_o[2])) else $error("disk line wrong");
   ring_follow_a: assert property (($stable(chan_b_port_i[7]))[*4] |-> modem_ring_n_o == chan_b_port_i[7])
      else $error("ring level not passed on");

   // Main scenarios reached
   cover property (!chan_a_int_request_n_o);
   cover property (ack_o && cyc_i);
   cover property ($fell(beeper_o));
endmodule // scp_port_checker

bind scp_port scp_port_checker #(.WIDTH(WIDTH)) scp_port_checker_i (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
   .chan_a_port_o, .chan_a_port_oe_o, .chan_b_port_i, .chan_b_port_o, .chan_b_port_oe_o, .chan_b_periph_line_o,
   .chan_b_periph_line_oe_o, .chan_a_int_request_n_o, .chan_b_int_request_n_o, .int_request_shared_oe_o,
   .bank_enable_o, .bank_enable_first_o, .bank_enable_video_o, .bank_enable_rom_o, .frame_rate_50_o,
   .modem_ring_n_o, .transmit_clock_choice_o, .receive_clock_choice_o, .drive_one_select_n_o,
   .drive_two_select_n_o, .double_density_n_o, .beeper_o);

// ==== verif/test_system_control_port.sv ====
// Bench for the system control port: bus model, pin levels, reference model.
// Assumes the design, its constants header, the bus model and the checker.
`timescale 1ns/1ns
`include "scp_consts.vh"
module test_system_control_port;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  pa_in = 8'h00;
   logic [7:0]  pb_in = 8'h80;
   logic        irq_a_in = 1'b1;
   logic        irq_b_in = 1'b0;
   wire         cyc, stb, we, ack, ca_o, ca_oe, cb_o, cb_oe, req_a_n, req_b_n, sh_o, sh_oe, frame, beep;
   wire [9:0]   adr;
   wire [3:0]   sel;
   wire [31:0]  wdat, rdat;
   wire [7:0]   pa_o, pa_oe, pb_o, pb_oe, bank;
   int          err_count = 0;
   int          n_tests = 0;
   int          dir_m[2], lat_m[2], cr_m[2], fl_m[2];
   logic [9:0]  bad[4] = '{10'h200, 10'h010, 10'h040, 10'h20C};

   always #4 clk_i = ~clk_i;

   scp_cpu_model scp_cpu_model_i (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
      .adr_o(adr), .sel_o(sel), .dat_o(wdat));
   scp_port scp_port_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .chan_a_port_i((pa_o & pa_oe) | (pa_in & ~pa_oe)),
      .chan_a_port_o(pa_o), .chan_a_port_oe_o(pa_oe), .chan_b_port_i((pb_o & pb_oe) | (pb_in & ~pb_oe)),
      .chan_b_port_o(pb_o), .chan_b_port_oe_o(pb_oe), .chan_a_irq_input_i(irq_a_in), .chan_b_irq_input_i(irq_b_in),
      .chan_a_periph_line_i(ca_oe ? ca_o : 1'b1), .chan_a_periph_line_o(ca_o), .chan_a_periph_line_oe_o(ca_oe),
      .chan_b_periph_line_i(cb_oe ? cb_o : 1'b1), .chan_b_periph_line_o(cb_o), .chan_b_periph_line_oe_o(cb_oe),
      .chan_a_int_request_n_o(req_a_n), .chan_b_int_request_n_o(req_b_n), .int_request_shared_i(sh_oe ? sh_o : 1'b1),
      .int_request_shared_o(sh_o), .int_request_shared_oe_o(sh_oe), .bank_enable_o(bank), .bank_enable_first_o(),
      .bank_enable_video_o(), .bank_enable_rom_o(), .frame_rate_50_o(frame), .modem_ring_n_o(),
      .transmit_clock_choice_o(), .receive_clock_choice_o(), .drive_one_select_n_o(), .drive_two_select_n_o(),
      .double_density_n_o(), .beeper_o(beep));

   // Prints the check count, reports the verdict and ends the run
   task automatic print_verdict;
      begin
         $display("checks %0d mismatches %0d", n_tests, err_count);
         if (err_count == 0 && n_tests > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask

   task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
      begin
         n_tests++;
         if (got !== ex) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
         end
      end
   endtask

   // Bus access that gives up on a missing answer
   task automatic bus(input bit w, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
      begin
         scp_cpu_model_i.xfer(w, a, d, q);
         if (scp_cpu_model_i.tmo) begin
            err_count++;
            print_verdict();
         end
         #1;
      end
   endtask

   // Reference model: pin levels and read values
   function automatic int pins(input int ch);
      int v;
      v = ch ? pb_in : pa_in;
      return ((lat_m[ch] & dir_m[ch]) | (v & ~dir_m[ch])) & 'hFF;
   endfunction

   function automatic int exp_rd(input int ch, input int ctl);
      if (ctl) return fl_m[ch] * 128 + cr_m[ch];
      if (cr_m[ch] & 4) return pins(ch);
      return dir_m[ch];
   endfunction

   task automatic wr(input int ch, input int ctl, input int d);
      logic [7:0] q;
      begin
         bus(1'b1, 10'(ch * 8 + ctl * 4), 8'(d), q);
         if (ctl) cr_m[ch] = d & 'h3F;
         else if (cr_m[ch] & 4) lat_m[ch] = d & 'hFF;
         else dir_m[ch] = d & 'hFF;
      end
   endtask

   task automatic rd(input int ch, input int ctl, input int msk);
      logic [7:0] q;
      begin
         // Let a fresh latch value pass the pin synchroniser first
         repeat (2) @(posedge clk_i);
         bus(1'b0, 10'(ch * 8 + ctl * 4), 8'h00, q);
         check("read value", exp_rd(ch, ctl) & msk, q & msk);
         if (!ctl && (cr_m[ch] & 4)) fl_m[ch] = 0;
      end
   endtask

   task automatic pins_chk;
      begin
         check("a latch", lat_m[0], pa_o);
         check("a direction", dir_m[0], pa_oe);
         check("bank enables", lat_m[0] & dir_m[0], bank);
         check("b latch", lat_m[1], pb_o);
         check("b direction", dir_m[1], pb_oe);
      end
   endtask

   task automatic wait_irq_a;
      int n;
      begin
         n = 0;
         while (req_a_n !== 1'b0 && n < 10) begin
            @(posedge clk_i);
            n++;
         end
         if (n >= 10) begin
            err_count++;
            print_verdict();
         end
      end
   endtask

   // Main sequence
   initial begin
      logic [7:0] q;
      void'($urandom(30));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      check("irq a idle", 1, req_a_n);
      pins_chk();
      // Random directions, latches and pin levels on both channels
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         pa_in <= 8'($urandom);
         pb_in <= 8'($urandom);
         for (int ch = 0; ch < 2; ch++) begin
            wr(ch, 1, 'h00);
            wr(ch, 0, $urandom & (ch ? 'h7F : 'hFF));
            rd(ch, 0, 'hFF);
            wr(ch, 1, 'h04);
            wr(ch, 0, $urandom);
            rd(ch, 0, ch ? 'h80 : 'hFF);
            rd(ch, 1, 'hFF);
            pins_chk();
         end
      end
      // Beeper follows channel B bit three
      for (int k = 1; k >= 0; k--) begin
         wr(1, 0, k * 8);
         check("beeper", dir_m[1] & 8 ? k : 0, (pb_oe[3] ? beep : 1'b0));
      end
      // Addresses outside the decode are ignored and read zero
      foreach (bad[j]) begin
         bus(1'b1, bad[j], 8'hA5, q);
         pins_chk();
         bus(1'b0, bad[j], 8'h00, q);
         check("alias read", 0, q);
      end
      // Channel A falling-edge interrupt, seen and cleared
      wr(0, 1, 'h05);
      @(posedge clk_i) irq_a_in <= 1'b0;
      wait_irq_a();
      fl_m[0] = 1;
      check("shared request", 1, sh_oe);
      rd(0, 1, 'hFF);
      rd(0, 0, 'hFF);
      check("irq a cleared", 1, req_a_n);
      // Channel B rising edge, masked then enabled
      wr(1, 1, 'h06);
      @(posedge clk_i) irq_b_in <= 1'b1;
      repeat (6) @(posedge clk_i);
      fl_m[1] = 1;
      check("irq b masked", 1, req_b_n);
      rd(1, 1, 'hFF);
      wr(1, 1, 'h07);
      check("irq b raised", 0, req_b_n);
      rd(1, 0, 'h80);
      check("irq b cleared", 1, req_b_n);
      // Peripheral lines driven low and high, then channel A's line released
      for (int m = 6; m < 8; m++) begin
         wr(0, 1, m * 8 + 4);
         wr(1, 1, m * 8 + 4);
         // Line levels follow the new mode one edge later
         @(posedge clk_i);
         #1;
         check("strobe enable", 1, ca_oe);
         check("strobe level", m & 1, ca_o);
         check("frame select", m & 1, frame);
      end
      wr(0, 1, 'h04);
      check("strobe released", 0, ca_oe);
      // Channel B line as a one-cycle write pulse, then as a handshake
      wr(1, 1, 'h2C);
      wr(1, 0, 'h00);
      check("pulse low", 0, frame);
      @(posedge clk_i);
      #1;
      check("pulse ended", 1, frame);
      wr(1, 1, 'h24);
      wr(1, 0, 'h00);
      check("handshake low", 0, frame);
      @(posedge clk_i) irq_b_in <= 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
      check("handshake high", 1, frame);
      // Reset in mid-run returns every line to input
      @(posedge clk_i) rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      dir_m = '{0, 0};
      lat_m = '{0, 0};
      @(posedge clk_i);
      #1;
      pins_chk();
      print_verdict();
   end
endmodule // test_system_control_port
